// ---- etc_defs.svh ----
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH

// ----------------------------------------
// clock and time base
// ----------------------------------------
`define ETC_CLK_HZ       25000000
`define ETC_TICK_HZ      256
`define ETC_TICK_DIV     (`ETC_CLK_HZ / `ETC_TICK_HZ)

// ----------------------------------------
// filter lengths in 256 Hz ticks
// ----------------------------------------
`define ETC_HYS0_TICKS   4'h0
`define ETC_HYS1_TICKS   4'h1
`define ETC_HYS2_TICKS   4'h4
`define ETC_HYS3_TICKS   4'h8

// ----------------------------------------
// sample periods as tick count masks
// ----------------------------------------
`define ETC_RATE1_MASK   10'h07f
`define ETC_RATE2_MASK   10'h0ff
`define ETC_RATE3_MASK   10'h3ff
`define ETC_SEC_MASK     10'h0ff

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ETC_OFF_CTRL     8'h00
`define ETC_OFF_STATUS   8'h04
`define ETC_OFF_TIME_LO  8'h08
`define ETC_OFF_TIME_HI  8'h0c
`define ETC_OFF_STAMP_LO 8'h10
`define ETC_OFF_STAMP_HI 8'h14
`define ETC_OFF_IRQ_STAT 8'h18
`define ETC_OFF_IRQ_MASK 8'h1c

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define ETC_CTRL_W       9
`define ETC_ST_FLAG      0
`define ETC_IRQ_W        2
`define ETC_IRQ_DETECT   0
`define ETC_IRQ_HALT     1
`define ETC_NFIELDS      6
`define ETC_TIME_RESET   48'h00_01_01_00_00_00

`endif

// ---- etc_pkg.sv ----
`include "etc_defs.svh"

package etc_pkg;

    typedef struct packed {
        logic       auto_clear_enable;
        logic       input_pullup_disable;
        logic       detect_out_batt_disable;
        logic       halt_on_detect;
        logic       detect_enable;
        logic [1:0] input_filter_sel;
        logic [1:0] sample_rate_sel;
    } etc_ctrl_t;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } etc_time_t;

    function automatic logic [3:0] etc_need_ticks(input logic [1:0] s);
        unique case (s)
            2'b00: etc_need_ticks = `ETC_HYS0_TICKS;
            2'b01: etc_need_ticks = `ETC_HYS1_TICKS;
            2'b10: etc_need_ticks = `ETC_HYS2_TICKS;
            2'b11: etc_need_ticks = `ETC_HYS3_TICKS;
        endcase
    endfunction

endpackage

// ---- etc_tick_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "etc_defs.svh"

module etc_tick_gen
#(
    parameter int TICK_DIV = `ETC_TICK_DIV
)
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    output logic            tick,
    output logic [9:0]      tick_cnt
);
    localparam int DW = $clog2(TICK_DIV);

    if (TICK_DIV < 2)
    begin : g_bad_div
        $error("etc_tick_gen: TICK_DIV must be at least 2");
    end

    logic [DW-1:0] div_cnt;
    localparam logic [DW-1:0] DIV_LAST = DW'(TICK_DIV - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt  <= '0;
            tick     <= 1'b0;
            tick_cnt <= 10'h000;
        end
        else
        begin
            tick <= (div_cnt == DIV_LAST);
            if (div_cnt == DIV_LAST)
            begin
                div_cnt  <= '0;
                tick_cnt <= tick_cnt + 10'h001;
            end
            else
            begin
                div_cnt <= div_cnt + DW'(1);
            end
        end
    end
endmodule

`default_nettype wire

// ---- etc_filter.sv ----
`timescale 1ns/10ps
`default_nettype none

module etc_filter
    import etc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic       din,
    input  wire logic [1:0] sel,
    output logic            ok
);
    logic [3:0] cnt;

    // counts whole ticks while the input stays high; a low resets it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt <= 4'h0;
        else if (!din)
            cnt <= 4'h0;
        else if (tick && cnt <= etc_need_ticks(sel))
            cnt <= cnt + 4'h1;
    end

    // cnt above need means at least need full tick periods elapsed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ok <= 1'b0;
        else
            ok <= din && (sel == 2'b00 || cnt > etc_need_ticks(sel));
    end

    default clocking fcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_filter_length: assert property ($rose(ok) && $past(sel) != 2'b00 |->
        $past(cnt) > etc_need_ticks($past(sel)))
        else $error("filter passed input before full interval");
endmodule

`default_nettype wire

// ---- etc_top.sv ----
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "etc_defs.svh"

module etc_top
    import etc_pkg::*;
#(
    parameter int TICK_DIV = `ETC_TICK_DIV
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tamper_input,
    input  wire logic        batt_mode,
    output logic             tamper_out_o,
    output logic             tamper_out_oe,
    output logic             pullup_en,
    output logic             irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    etc_ctrl_t              ctrl;
    etc_time_t              time_q;
    etc_time_t              stamp;
    logic                   tamper_flag;
    logic                   halted;
    logic [`ETC_IRQ_W-1:0]  irq_stat;
    logic [`ETC_IRQ_W-1:0]  irq_mask;
    logic                   tick;
    logic [9:0]             tick_cnt;
    logic                   filt_ok;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic at_wrap(input logic [9:0] c, input logic [9:0] m);
        at_wrap = (c & m) == 10'h000;
    endfunction

    function automatic logic [9:0] rate_mask(input logic [1:0] s);
        unique case (s)
            2'b00: rate_mask = 10'h000;
            2'b01: rate_mask = `ETC_RATE1_MASK;
            2'b10: rate_mask = `ETC_RATE2_MASK;
            2'b11: rate_mask = `ETC_RATE3_MASK;
        endcase
    endfunction

    function automatic logic [7:0] fld_max(input logic [2:0] i);
        unique case (i)
            3'h0, 3'h1: fld_max = 8'h3b;
            3'h2:       fld_max = 8'h17;
            3'h3:       fld_max = 8'h1f;
            3'h4:       fld_max = 8'h0c;
            default:    fld_max = 8'h63;
        endcase
    endfunction

    function automatic logic [7:0] fld_min(input logic [2:0] i);
        fld_min = (i == 3'h3 || i == 3'h4) ? 8'h01 : 8'h00;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------
    // time base and input filter
    // ----------------------------------------
    etc_tick_gen #(
        .TICK_DIV (TICK_DIV)
    ) u_tick (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick),
        .tick_cnt (tick_cnt)
    );

    etc_filter u_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .din     (tamper_input),
        .sel     (ctrl.input_filter_sel),
        .ok      (filt_ok)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic acc;
    logic wr;
    logic rd;
    logic mapped;

    assign acc    = psel && penable && !pready;
    assign wr     = psel && penable && pready && pwrite;
    assign rd     = psel && penable && pready && !pwrite;
    assign mapped = paddr[7:5] == 3'b000 && paddr[1:0] == 2'b00;

    logic wr_ctrl;
    logic wr_stat;
    logic rd_stat;
    logic wr_lo;
    logic wr_hi;
    logic wr_istat;
    logic wr_imask;

    assign wr_ctrl  = wr && hit(paddr, `ETC_OFF_CTRL);
    assign wr_stat  = wr && hit(paddr, `ETC_OFF_STATUS);
    assign rd_stat  = rd && hit(paddr, `ETC_OFF_STATUS);
    assign wr_lo    = wr && hit(paddr, `ETC_OFF_TIME_LO);
    assign wr_hi    = wr && hit(paddr, `ETC_OFF_TIME_HI);
    assign wr_istat = wr && hit(paddr, `ETC_OFF_IRQ_STAT);
    assign wr_imask = wr && hit(paddr, `ETC_OFF_IRQ_MASK);

    // ----------------------------------------
    // sampling and detection
    // ----------------------------------------
    logic       sample;
    logic       detect;
    logic       sec_tick;
    logic [9:0] rm;
    logic       set_halt;

    assign rm       = rate_mask(ctrl.sample_rate_sel);
    // periodic modes look at the filtered input only on the rate wrap
    assign sample   = ctrl.sample_rate_sel == 2'b00 || (tick && at_wrap(tick_cnt, rm));
    assign detect   = ctrl.detect_enable && sample && filt_ok;
    assign sec_tick = tick && at_wrap(tick_cnt, `ETC_SEC_MASK);
    assign set_halt = detect && ctrl.halt_on_detect;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= '0;
        else if (wr_ctrl)
            ctrl <= etc_ctrl_t'(pwdata[`ETC_CTRL_W-1:0]);
        else if (wr_hi && halted && !set_halt)
            ctrl.halt_on_detect <= 1'b0;
    end

    // ----------------------------------------
    // event flag, halt and stamp
    // ----------------------------------------
    logic flag_clr;

    // a read clears only a flag that it returned, so an event during the read survives
    assign flag_clr = (wr_stat && !pwdata[`ETC_ST_FLAG]) ||
                      (rd_stat && ctrl.auto_clear_enable && prdata[`ETC_ST_FLAG]);

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tamper_flag <= 1'b0;
        else
            tamper_flag <= detect || (tamper_flag && !flag_clr);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            halted <= 1'b0;
        else
            halted <= set_halt || (halted && !wr_hi);
    end

    // no software path writes the stamp; only power-up reset clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stamp <= '0;
        else if (detect && (!tamper_flag || flag_clr))
            stamp <= time_q;
    end

    // ----------------------------------------
    // time counter
    // ----------------------------------------
    logic [`ETC_NFIELDS-1:0][7:0] next_fields;
    logic                         carry;

    // limits are plain day counts; month length is not modelled
    always_comb
    begin
        next_fields = time_q;
        carry       = sec_tick && !halted;
        for (int i = 0; i < `ETC_NFIELDS; i++)
        begin
            if (carry)
            begin
                if (next_fields[i] == fld_max(3'(i)))
                    next_fields[i] = fld_min(3'(i));
                else
                begin
                    next_fields[i] = next_fields[i] + 8'h01;
                    carry          = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            time_q <= etc_time_t'(`ETC_TIME_RESET);
        else if (wr_lo)
            time_q[31:0] <= pwdata;
        else if (wr_hi)
            time_q[47:32] <= pwdata[15:0];
        else
            time_q <= etc_time_t'(next_fields);
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [`ETC_IRQ_W-1:0] irq_set;
    logic [`ETC_IRQ_W-1:0] irq_clr;

    assign irq_set = {set_halt, detect};
    assign irq_clr = wr_istat ? pwdata[`ETC_IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= '0;
        else
            irq_stat <= irq_set | (irq_stat & ~irq_clr);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= '0;
        else if (wr_imask)
            irq_mask <= pwdata[`ETC_IRQ_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_mask);
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    logic [3:0] need;
    logic       next_pullup;

    assign need        = etc_need_ticks(ctrl.input_filter_sel);
    // in periodic modes with a filter selected the source only runs for the filter span before a sample
    assign next_pullup = !ctrl.input_pullup_disable &&
                         (ctrl.input_filter_sel == 2'b00 || ctrl.sample_rate_sel == 2'b00 ||
                          (tick_cnt & rm) >= (rm - {6'h00, need}));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pullup_en     <= 1'b0;
            tamper_out_oe <= 1'b0;
            tamper_out_o  <= 1'b0;
        end
        else
        begin
            pullup_en     <= next_pullup;
            tamper_out_oe <= tamper_flag && !(batt_mode && ctrl.detect_out_batt_disable);
            tamper_out_o  <= 1'b0;
        end
    end

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    logic [31:0] next_prdata;

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            `ETC_OFF_CTRL:     next_prdata = {23'h000000, ctrl};
            `ETC_OFF_STATUS:   next_prdata = {29'h00000000, batt_mode, halted, tamper_flag};
            `ETC_OFF_TIME_LO:  next_prdata = time_q[31:0];
            `ETC_OFF_TIME_HI:  next_prdata = {16'h0000, time_q[47:32]};
            `ETC_OFF_STAMP_LO: next_prdata = stamp[31:0];
            `ETC_OFF_STAMP_HI: next_prdata = {16'h0000, stamp[47:32]};
            `ETC_OFF_IRQ_STAT: next_prdata = {30'h00000000, irq_stat};
            `ETC_OFF_IRQ_MASK: next_prdata = {30'h00000000, irq_mask};
            default:           next_prdata = 32'h0000_0000;
        endcase
    end

    // one wait state so the answer comes from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc && !mapped;
            if (acc)
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_rate_instants: assert property (detect && ctrl.sample_rate_sel == 2'b01 |->
        tick && (tick_cnt & `ETC_RATE1_MASK) == 10'h000)
        else $error("2Hz detect off sample instant");
    chk_detect_gated: assert property (!ctrl.detect_enable |-> !detect ##1 $stable(stamp))
        else $error("detect while disabled");
    chk_stamp_first: assert property (tamper_flag && !flag_clr |=> $stable(stamp))
        else $error("stamp overwritten while flag set");
    chk_stamp_cause: assert property (!$stable(stamp) |->
        $past(detect) && (!$past(tamper_flag) || $past(flag_clr)))
        else $error("stamp changed without event");
    chk_halt_freezes: assert property (halted && !wr_lo && !wr_hi |=> $stable(time_q))
        else $error("time moved while halted");
    chk_halt_resume: assert property (halted && wr_hi && !set_halt |=> !halted ##0 !ctrl.halt_on_detect)
        else $error("halt not released by time write");
    chk_halt_enabled: assert property ($rose(halted) |-> $past(ctrl.detect_enable))
        else $error("halt without detection enabled");
    chk_flag_event: assert property (detect |=>
        tamper_flag ##1 (tamper_out_oe || $past(batt_mode && ctrl.detect_out_batt_disable)))
        else $error("event did not set flag and output");
    chk_auto_clear: assert property (rd_stat && ctrl.auto_clear_enable && prdata[`ETC_ST_FLAG] && !detect |=>
        !tamper_flag)
        else $error("auto clear failed");
    chk_batt_off: assert property (batt_mode && ctrl.detect_out_batt_disable |=> !tamper_out_oe)
        else $error("event output active in battery mode");
    chk_pullup_off: assert property (ctrl.input_pullup_disable |=> !pullup_en)
        else $error("pull-up on while disabled");
    chk_periodic_tick: assert property (detect && ctrl.sample_rate_sel != 2'b00 |-> tick)
        else $error("periodic detect off tick");

    cov_event_stamp: cover property (detect && !tamper_flag ##1 tamper_flag);
    cov_halt_restart: cover property (set_halt ##[1:1000] wr_hi);
    cov_auto_clear: cover property (tamper_flag && rd_stat && ctrl.auto_clear_enable);
endmodule

`default_nettype wire

// ---- etc_tamper_sw.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// tamper sensor driving the event pin
// ----------------------------------------
module etc_tamper_sw
(
    input  wire logic pclk,
    input  wire logic level,
    input  wire logic noisy,
    output logic      pin
);
    // chatter: two cycles high, two low, shorter than any filter tick
    logic [1:0] ph = 2'h0;

    always_ff @(posedge pclk)
        ph <= ph + 2'h1;

    assign pin = noisy ? ph[1] : level;
endmodule
`default_nettype wire

// ---- tb_event_detect_timestamp_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "etc_defs.svh"

module tb_event_detect_timestamp_ctrl;
    // ----------------------------------------
    // clock, pins and bookkeeping
    // ----------------------------------------
    localparam int TDIV = 4;
    localparam int SEC  = 256 * TDIV;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        level = 1'b0;
    logic        noisy = 1'b0;
    logic        batt_mode = 1'b0;
    logic        tamper_input;
    logic        tamper_out_o;
    logic        tamper_out_oe;
    logic        pullup_en;
    logic        irq;
    integer      seed = 66;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [64:0] notes[$];
    logic [31:0] rdv;

    always #20 pclk = ~pclk;

    etc_tamper_sw SW (.pclk(pclk), .level(level), .noisy(noisy), .pin(tamper_input));

    etc_top #(.TICK_DIV(TDIV)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tamper_input(tamper_input), .batt_mode(batt_mode),
        .tamper_out_o(tamper_out_o), .tamper_out_oe(tamper_out_oe), .pullup_en(pullup_en), .irq(irq));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] rnd(input int lim);
        rnd = 8'($unsigned($random(seed)) % lim);
    endfunction

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
                      input logic err = 1'b0);
        notes.push_back({err, m, e});
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic wait_oe(input logic v, output int n);
        n = 0;
        while (tamper_out_oe !== v && n < 6000)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic pulse();
        @(posedge pclk);
        level <= 1'b1;
        repeat (40) @(posedge pclk);
        level <= 1'b0;
    endtask

    // read results compared against the oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            logic [64:0] nt;
            nt = notes.pop_front();
            check(32'(pslverr), 32'(nt[64]));
            check(prdata & nt[63:32], nt[31:0] & nt[63:32]);
        end

    // hang guard; the longest rate test needs about 8200 cycles
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            mismatches++;
            final_report();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        int n;
        int t0;
        int need;
        int per[4];
        logic [31:0] lo1, lo2, hi1;
        per = '{0, SEC / 2, SEC, SEC * 4};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ETC_OFF_CTRL, 32'h0);
        rd(`ETC_OFF_STATUS, 32'h0);
        rd(`ETC_OFF_TIME_LO, 32'h01000000);
        rd(`ETC_OFF_STAMP_LO, 32'h0);
        rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
        $display("test reset done");
        wr(`ETC_OFF_CTRL, 32'h20);
        pulse();
        check(32'(tamper_out_oe), 32'h0);
        rd(`ETC_OFF_STATUS, 32'h0, 32'h3);
        $display("test disabled done");
        lo1 = {8'h07, 8'h03, rnd(59), rnd(50)};
        hi1 = {16'h0, 8'h02, rnd(99)};
        wr(`ETC_OFF_TIME_LO, lo1);
        wr(`ETC_OFF_TIME_HI, hi1);
        wr(`ETC_OFF_CTRL, 32'h10);
        pulse();
        check(32'(tamper_out_oe), 32'h1);
        check(32'(tamper_out_o), 32'h0);
        check(32'(pullup_en), 32'h1);
        rd(`ETC_OFF_STATUS, 32'h1, 32'h1);
        rd(`ETC_OFF_STAMP_LO, lo1);
        rd(`ETC_OFF_STAMP_HI, hi1);
        lo2 = lo1 + 32'h100;
        wr(`ETC_OFF_TIME_LO, lo2);
        pulse();
        rd(`ETC_OFF_STAMP_LO, lo1);
        wr(`ETC_OFF_STAMP_LO, 32'h0);
        rd(`ETC_OFF_STAMP_LO, lo1);
        wr(`ETC_OFF_STATUS, 32'h0);
        rd(`ETC_OFF_STATUS, 32'h0, 32'h1);
        wr(`ETC_OFF_STATUS, 32'h1);
        rd(`ETC_OFF_STATUS, 32'h0, 32'h1);
        check(32'(tamper_out_oe), 32'h0);
        pulse();
        rd(`ETC_OFF_STAMP_LO, lo2);
        wr(`ETC_OFF_STATUS, 32'h0);
        wr(`ETC_OFF_CTRL, 32'h110);
        pulse();
        rd(`ETC_OFF_STATUS, 32'h1, 32'h1);
        rd(`ETC_OFF_STATUS, 32'h0, 32'h1);
        $display("test stamp and clear done");
        wr(`ETC_OFF_CTRL, 32'h50);
        batt_mode <= 1'b1;
        pulse();
        check(32'(tamper_out_oe), 32'h0);
        rd(`ETC_OFF_STATUS, 32'h5, 32'h5);
        batt_mode <= 1'b0;
        repeat (4) @(posedge pclk);
        check(32'(tamper_out_oe), 32'h1);
        wr(`ETC_OFF_CTRL, 32'h10);
        batt_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        check(32'(tamper_out_oe), 32'h1);
        batt_mode <= 1'b0;
        wr(`ETC_OFF_CTRL, 32'h90);
        repeat (4) @(posedge pclk);
        check(32'(pullup_en), 32'h0);
        $display("test battery and pull-up done");
        for (int s = 1; s < 4; s++)
        begin
            need = (s == 1) ? 1 : (s == 2) ? 4 : 8;
            wr(`ETC_OFF_STATUS, 32'h0);
            wr(`ETC_OFF_CTRL, 32'h10 | 32'(s << 2));
            level <= 1'b1;
            repeat (need * 4 - 1) @(posedge pclk);
            level <= 1'b0;
            // a low gap first, so the chatter cannot stretch the high run above
            repeat (4) @(posedge pclk);
            noisy <= 1'b1;
            repeat (100) @(posedge pclk);
            noisy <= 1'b0;
            repeat (20) @(posedge pclk);
            check(32'(tamper_out_oe), 32'h0);
            level <= 1'b1;
            wait_oe(1'b1, n);
            check(32'(n >= need * 4 && n <= need * 4 + 12), 32'h1);
            level <= 1'b0;
        end
        $display("test filter done");
        for (int r = 0; r < 4; r++)
        begin
            wr(`ETC_OFF_STATUS, 32'h0);
            wr(`ETC_OFF_CTRL, 32'h14 | 32'(r));
            level <= 1'b1;
            wait_oe(1'b1, n);
            check(32'(n <= per[r] + 12), 32'h1);
            if (r > 0)
            begin
                t0 = cyc;
                wr(`ETC_OFF_STATUS, 32'h0);
                wait_oe(1'b0, n);
                wait_oe(1'b1, n);
                check(32'(cyc - t0), 32'(per[r]));
                repeat (8) @(posedge pclk);
                check(32'(pullup_en), 32'h0);
            end
            level <= 1'b0;
        end
        $display("test rate done");
        wr(`ETC_OFF_STATUS, 32'h0);
        wr(`ETC_OFF_IRQ_STAT, 32'h3);
        wr(`ETC_OFF_IRQ_MASK, 32'h2);
        lo1 = {8'h09, 8'h04, rnd(59), rnd(50)};
        // seconds step a fixed phase after reset; keep the writes and the halt clear of it
        while (cyc % SEC != 100)
            @(posedge pclk);
        wr(`ETC_OFF_TIME_LO, lo1);
        wr(`ETC_OFF_TIME_HI, hi1);
        wr(`ETC_OFF_CTRL, 32'h30);
        pulse();
        repeat (1100) @(posedge pclk);
        rd(`ETC_OFF_TIME_LO, lo1);
        rd(`ETC_OFF_STATUS, 32'h3, 32'h3);
        check(32'(irq), 32'h1);
        wr(`ETC_OFF_IRQ_STAT, 32'h2);
        repeat (3) @(posedge pclk);
        check(32'(irq), 32'h0);
        wr(`ETC_OFF_IRQ_MASK, 32'h1);
        repeat (3) @(posedge pclk);
        check(32'(irq), 32'h1);
        wr(`ETC_OFF_IRQ_STAT, 32'h1);
        repeat (3) @(posedge pclk);
        check(32'(irq), 32'h0);
        wr(`ETC_OFF_TIME_LO, lo1);
        wr(`ETC_OFF_TIME_HI, hi1);
        rd(`ETC_OFF_CTRL, 32'h10, 32'h1ff);
        rd(`ETC_OFF_STATUS, 32'h0, 32'h2);
        repeat (1100) @(posedge pclk);
        rd(`ETC_OFF_TIME_LO, lo1 + 32'h1);
        $display("test halt done");
        final_report();
    end
endmodule
`default_nettype wire
